// ===== src/channel_wave_gen.sv
`timescale 1ns/1ps
`include "wave_ctrl_defines.svh"

module channel_wave_gen #(
    parameter bit IS_CHAN_A = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wave_ctrl_pkg::mode_class_t cls,
    input wire logic [3:0] mode,
    input wire logic [1:0] action,
    input wire logic match,
    input wire logic cmp_top,
    input wire logic cmp_bottom,
    input wire logic at_top,
    input wire logic at_bottom,
    input wire logic counting_down,
    output logic wave_ff
);

logic fast_tog_ok;
logic dual_tog_ok;
logic inv;

// only channel A gets a toggle in the pwm classes
assign fast_tog_ok = IS_CHAN_A && (mode >= `FAST_TOG_LO) && (mode <= `FAST_TOG_HI); // [RULE7]
assign dual_tog_ok = IS_CHAN_A && (mode >= `DUAL_TOG_LO) && (mode <= `DUAL_TOG_HI); // [RULE10]
assign inv = action[0];

always_ff @(posedge clk)
begin
    if (rst)
        wave_ff <= `WAVE_RESET;
    else if (action != `ACT_OFF)
    begin
        unique case (cls)
            wave_ctrl_pkg::CLASS_NON_PWM:
            begin
                if (match)
                begin
                    unique case (action)
                        `ACT_TOGGLE: wave_ff <= ~wave_ff; // [RULE5]
                        `ACT_CLEAR: wave_ff <= 1'b0; // [RULE5]
                        `ACT_SET: wave_ff <= 1'b1; // [RULE5]
                        default: wave_ff <= wave_ff;
                    endcase
                end
            end
            wave_ctrl_pkg::CLASS_FAST:
            begin
                if (action == `ACT_TOGGLE)
                begin
                    if (match && fast_tog_ok)
                        wave_ff <= ~wave_ff; // [RULE7]
                end
                // top wins; a match at top is dropped
                else if (at_top)
                    wave_ff <= 1'b1 ^ inv; // [RULE6] [RULE8]
                else if (match && !cmp_top)
                    wave_ff <= 1'b0 ^ inv; // [RULE6] [RULE8]
            end
            wave_ctrl_pkg::CLASS_DUAL:
            begin
                if (action == `ACT_TOGGLE)
                begin
                    if (match && dual_tog_ok)
                        wave_ff <= ~wave_ff; // [RULE10]
                end
                else if (cmp_bottom)
                    wave_ff <= 1'b0 ^ inv; // [RULE12]
                else if (cmp_top)
                    wave_ff <= 1'b1 ^ inv; // [RULE12]
                else if (match)
                    wave_ff <= counting_down ^ inv; // [RULE9]
            end
            wave_ctrl_pkg::CLASS_NONE:
                wave_ff <= wave_ff;
        endcase
    end
end

endmodule : channel_wave_gen

// ===== src/timer_mode_decode.sv
`timescale 1ns/1ps
`include "wave_ctrl_defines.svh"

module timer_mode_decode (
    input wire logic [7:0] ctrl,
    input wire logic [1:0] high_bits,
    output wave_ctrl_pkg::timer_setup_t setup
);

logic [3:0] mode;

assign mode = {high_bits, ctrl[`MODE_LO_MSB:`MODE_LO_LSB]}; // [RULE11]

always_comb
begin
    setup.mode = mode;
    setup.cls = wave_ctrl_pkg::classify_mode(mode); // [RULE4]
    setup.action[0] = ctrl[`ACT_A_MSB:`ACT_A_LSB]; // [RULE1]
    setup.action[1] = ctrl[`ACT_B_MSB:`ACT_B_LSB]; // [RULE1]
    setup.action[2] = ctrl[`ACT_C_MSB:`ACT_C_LSB]; // [RULE1]
end

endmodule : timer_mode_decode

// ===== src/wave_ctrl_defines.svh
`ifndef WAVE_CTRL_DEFINES_SVH
`define WAVE_CTRL_DEFINES_SVH

// register word indices; byte address is index times four
`define IDX_CTRL_FIRST 6'h00
`define IDX_HIGH_FIRST 6'h04
`define IDX_STATUS 6'h08
`define IDX_LAST 6'h08
`define IDX_TIMER_MASK 6'h03
`define IDX_LSB 2
`define IDX_MSB 7

`define CTRL_RESET 8'h00
`define HIGH_RESET 2'h0

// first control register fields
`define ACT_A_MSB 7
`define ACT_A_LSB 6
`define ACT_B_MSB 5
`define ACT_B_LSB 4
`define ACT_C_MSB 3
`define ACT_C_LSB 2
`define MODE_LO_MSB 1
`define MODE_LO_LSB 0
// upper mode bits sit where the second timer control keeps them
`define MODE_HI_MSB 4
`define MODE_HI_LSB 3

// modes that let channel A toggle with action 01
`define FAST_TOG_LO 4'hE
`define FAST_TOG_HI 4'hF
`define DUAL_TOG_LO 4'h8
`define DUAL_TOG_HI 4'hB

`define ACT_OFF 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_CLEAR 2'h2
`define ACT_SET 2'h3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define WAVE_RESET 1'b0

`endif

// ===== src/wave_ctrl_pkg.sv
package wave_ctrl_pkg;

typedef enum logic [1:0] {
    CLASS_NON_PWM = 2'h0,
    CLASS_FAST = 2'h1,
    CLASS_DUAL = 2'h3,
    CLASS_NONE = 2'h2
} mode_class_t;

typedef struct packed {
    logic [2:0] match;
    logic [2:0] cmp_top;
    logic [2:0] cmp_bottom;
    logic at_top;
    logic at_bottom;
    logic counting_down;
} timer_event_t;

typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
} axil_req_t;

typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
} axil_rsp_t;

typedef struct packed {
    mode_class_t cls;
    logic [3:0] mode;
    logic [2:0][1:0] action;
} timer_setup_t;

function automatic mode_class_t classify_mode(input logic [3:0] m);
    mode_class_t c;
    c = CLASS_NONE;
    unique case (m)
        4'h0, 4'h4, 4'hC: c = CLASS_NON_PWM;
        4'h5, 4'h6, 4'h7, 4'hE, 4'hF: c = CLASS_FAST;
        4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: c = CLASS_DUAL;
        4'hD: c = CLASS_NONE;
    endcase
    return c;
endfunction : classify_mode

endpackage : wave_ctrl_pkg

// ===== src/wave_ctrl_top.sv
// How it works
// [RULE1] action fields A 7:6, B 5:4, C 3:2, mode 1:0
// [RULE2] nonzero action hands pin to waveform
// [RULE3] software sets pin direction to output
// [RULE4] mode class selects action meaning
// [RULE5] non-pwm: off, toggle, clear, set on match
// [RULE6] fast: 10 clear match/set top, 11 reverse
// [RULE7] fast 01 toggles A only in modes 14,15
// [RULE8] fast: match at top ignored, top acts
// [RULE9] dual-slope: 10 clear up, set down
// [RULE10] dual-slope 01 toggles A only modes 8-11
// [RULE11] low mode bits join upper two bits
// [RULE12] dual-slope compare at bottom/top holds level
// [RULE13] four independent timer instances
`timescale 1ns/1ps
`include "wave_ctrl_defines.svh"

module wave_ctrl_top #(
    parameter int NUM_TIMERS = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wave_ctrl_pkg::axil_req_t axil_req,
    output wave_ctrl_pkg::axil_rsp_t axil_rsp,
    input wave_ctrl_pkg::timer_event_t [NUM_TIMERS-1:0] tmr_evt,
    output logic [NUM_TIMERS-1:0][2:0] wave_out,
    output logic [NUM_TIMERS-1:0][2:0] wave_override
);

logic [NUM_TIMERS-1:0][7:0] ctrl_ff;
logic [NUM_TIMERS-1:0][1:0] high_ff;
logic [NUM_TIMERS-1:0][2:0] override_ff;
wave_ctrl_pkg::timer_setup_t [NUM_TIMERS-1:0] setup;

logic awready_ff;
logic aw_held_ff;
logic [7:0] waddr_ff;
logic wready_ff;
logic w_held_ff;
logic [31:0] wdata_ff;
logic [3:0] wstrb_ff;
logic bvalid_ff;
logic [1:0] bresp_ff;
logic arready_ff;
logic rvalid_ff;
logic [31:0] rdata_ff;
logic [1:0] rresp_ff;

logic wr_commit;
logic wr_done;
logic wr_ok;
logic [5:0] wr_idx;
logic rd_ok;
logic [5:0] rd_idx;
logic [31:0] rd_word;
logic wr_lane0;
logic [NUM_TIMERS-1:0] ctrl_wr_en;
logic [NUM_TIMERS-1:0] high_wr_en;
logic [31:0] status_word;
logic [NUM_TIMERS-1:0][2:0] nxt_override;

function automatic logic [5:0] word_index(input logic [7:0] addr);
    return addr[`IDX_MSB:`IDX_LSB];
endfunction : word_index

function automatic logic index_mapped(input logic [5:0] idx);
    return idx <= `IDX_LAST;
endfunction : index_mapped

function automatic logic [5:0] ctrl_index(input int n);
    return `IDX_CTRL_FIRST + 6'(n);
endfunction : ctrl_index

function automatic logic [5:0] high_index(input int n);
    return `IDX_HIGH_FIRST + 6'(n);
endfunction : high_index

// unmapped words answer with an error so a wrong address shows up in software
function automatic logic [1:0] resp_code(input logic ok);
    return ok ? `RESP_OKAY : `RESP_SLVERR;
endfunction : resp_code

// fields are placed by name so the response keeps its meaning if the struct is reordered
always_comb
begin
    axil_rsp.awready = awready_ff;
    axil_rsp.wready = wready_ff;
    axil_rsp.bvalid = bvalid_ff;
    axil_rsp.bresp = bresp_ff;
    axil_rsp.arready = arready_ff;
    axil_rsp.rvalid = rvalid_ff;
    axil_rsp.rdata = rdata_ff;
    axil_rsp.rresp = rresp_ff;
end

// write address and data are taken in either order, held until the response is accepted
assign wr_commit = aw_held_ff && w_held_ff && !bvalid_ff;
assign wr_done = bvalid_ff && axil_req.bready;
assign wr_idx = word_index(waddr_ff);
assign wr_ok = index_mapped(wr_idx);
assign wr_lane0 = wr_commit && wstrb_ff[0];

// one decoded enable per register keeps each timer's flops apart from the others
always_comb
begin
    ctrl_wr_en = '0;
    high_wr_en = '0;
    for (int i = 0; i < NUM_TIMERS; i++)
    begin
        ctrl_wr_en[i] = wr_lane0 && (wr_idx == ctrl_index(i));
        high_wr_en[i] = wr_lane0 && (wr_idx == high_index(i));
    end
end

// awready stays low from the take until the response is accepted: one write at a time

always_ff @(posedge clk)
begin
    if (rst)
    begin
        awready_ff <= 1'b0;
        aw_held_ff <= 1'b0;
        waddr_ff <= 8'h00;
    end
    else if (axil_req.awvalid && awready_ff)
    begin
        awready_ff <= 1'b0;
        aw_held_ff <= 1'b1;
        waddr_ff <= axil_req.awaddr;
    end
    else if (wr_done)
    begin
        aw_held_ff <= 1'b0;
        awready_ff <= 1'b1;
    end
    else if (!aw_held_ff)
        awready_ff <= 1'b1;
end

always_ff @(posedge clk)
begin
    if (rst)
    begin
        wready_ff <= 1'b0;
        w_held_ff <= 1'b0;
        wdata_ff <= 32'h00000000;
        wstrb_ff <= 4'h0;
    end
    else if (axil_req.wvalid && wready_ff)
    begin
        wready_ff <= 1'b0;
        w_held_ff <= 1'b1;
        wdata_ff <= axil_req.wdata;
        wstrb_ff <= axil_req.wstrb;
    end
    else if (wr_done)
    begin
        w_held_ff <= 1'b0;
        wready_ff <= 1'b1;
    end
    else if (!w_held_ff)
        wready_ff <= 1'b1;
end

always_ff @(posedge clk)
begin
    if (rst)
    begin
        bvalid_ff <= 1'b0;
        bresp_ff <= `RESP_OKAY;
    end
    else if (wr_commit)
    begin
        bvalid_ff <= 1'b1;
        bresp_ff <= resp_code(wr_ok);
    end
    else if (wr_done)
        bvalid_ff <= 1'b0;
end

// the writable registers are one byte wide, so only lane 0 is honoured; the status word ignores writes
genvar t;
generate
    for (t = 0; t < NUM_TIMERS; t++)
    begin : g_timer
        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                ctrl_ff[t] <= `CTRL_RESET;
                high_ff[t] <= `HIGH_RESET;
            end
            // both enables come from one decoded index, so a write touches one register at most
            else
            begin
                if (ctrl_wr_en[t])
                    ctrl_ff[t] <= wdata_ff[7:0]; // [RULE1]
                if (high_wr_en[t])
                    high_ff[t] <= wdata_ff[`MODE_HI_MSB:`MODE_HI_LSB]; // [RULE11]
            end
        end

        timer_mode_decode u_decode (
            .ctrl(ctrl_ff[t]),
            .high_bits(high_ff[t]),
            .setup(setup[t])
        );

        always_ff @(posedge clk)
        begin
            if (rst)
                override_ff[t] <= 3'h0;
            else
                override_ff[t] <= nxt_override[t]; // [RULE2]
        end

        // each timer sees only its own comparator events
        for (genvar c = 0; c < 3; c++)
        begin : g_chan
            channel_wave_gen #(
                .IS_CHAN_A(c == 0)
            ) u_chan (
                .clk(clk),
                .rst(rst),
                .cls(setup[t].cls),
                .mode(setup[t].mode),
                .action(setup[t].action[c]),
                .match(tmr_evt[t].match[c]),
                .cmp_top(tmr_evt[t].cmp_top[c]),
                .cmp_bottom(tmr_evt[t].cmp_bottom[c]),
                .at_top(tmr_evt[t].at_top),
                .at_bottom(tmr_evt[t].at_bottom),
                .counting_down(tmr_evt[t].counting_down),
                .wave_ff(wave_out[t][c])
            ); // [RULE13]
        end
    end
endgenerate

assign wave_override = override_ff;

// a nonzero action field takes the pin away from the port logic, one channel at a time
always_comb
begin
    nxt_override = '0;
    for (int i = 0; i < NUM_TIMERS; i++)
    begin
        for (int c = 0; c < 3; c++)
        begin
            nxt_override[i][c] = setup[i].action[c] != `ACT_OFF; // [RULE2]
        end
    end
end

// status mirrors the live outputs; it is read only, so writes to it are answered and dropped
assign status_word = {4'h0, 12'(override_ff), 4'h0, 12'(wave_out)};

assign rd_idx = word_index(axil_req.araddr);
assign rd_ok = index_mapped(rd_idx);

// the read word is picked from the live address and captured at the take

always_comb
begin
    rd_word = 32'h00000000;
    if (rd_idx == `IDX_STATUS)
        rd_word = status_word;
    else
    begin
        // the two index ranges never overlap, so at most one match per word
        for (int i = 0; i < NUM_TIMERS; i++)
        begin
            if (rd_idx == ctrl_index(i))
                rd_word = {24'h000000, ctrl_ff[i]};
            if (rd_idx == high_index(i))
                rd_word = {27'h0000000, high_ff[i], 3'h0};
        end
    end
end

always_ff @(posedge clk)
begin
    if (rst)
    begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b0;
        rdata_ff <= 32'h00000000;
        rresp_ff <= `RESP_OKAY;
    end
    else if (axil_req.arvalid && arready_ff)
    begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_ok ? rd_word : 32'h00000000;
        rresp_ff <= resp_code(rd_ok);
    end
    else if (rvalid_ff && axil_req.rready)
    begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
    end
    else if (!rvalid_ff)
        arready_ff <= 1'b1;
end

endmodule : wave_ctrl_top

// ===== verification/pin_model.sv
`timescale 1ns/1ps
module pin_model #(
    parameter int N = 12
) (
    input wire logic [N-1:0] wave,
    input wire logic [N-1:0] ovr,
    input wire logic [N-1:0] port_val,
    input wire logic [N-1:0] dir_out,
    output logic [N-1:0] pin
);
always_comb
begin
    for (int i = 0; i < N; i++)
    begin
        // a pin left as input floats to its pull-up, so the waveform never shows there
        pin[i] = dir_out[i] ? (ovr[i] ? wave[i] : port_val[i]) : 1'b1;
    end
end
endmodule : pin_model

// ===== verification/timer16_compare_output_control_bench.sv
`timescale 1ns/1ps
`include "wave_ctrl_defines.svh"
module timer16_compare_output_control_bench;
logic clk = 1'b0;
logic rst = 1'b1;
wave_ctrl_pkg::axil_req_t req = '0;
wave_ctrl_pkg::axil_rsp_t rsp;
wave_ctrl_pkg::timer_event_t [3:0] evt = '0;
logic [3:0][2:0] wave;
logic [3:0][2:0] ovr;
logic [11:0] dir = 12'h000;
logic [11:0] pin;
logic [31:0] d;
logic [1:0] r;
int miscompares = 0;
int n_tests = 0;
always #25 clk = ~clk;
wave_ctrl_top #(.NUM_TIMERS(4)) dut_u (.clk(clk), .rst(rst), .axil_req(req), .axil_rsp(rsp),
    .tmr_evt(evt), .wave_out(wave), .wave_override(ovr));
pin_model #(.N(12)) far_u (.wave(wave), .ovr(ovr), .port_val(12'h000), .dir_out(dir), .pin(pin));
task results;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask : results
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
        miscompares++;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
endtask : chk
task cw(input logic [2:0] e);
    chk("wave", 32'(e), 32'(wave[0]));
endtask : cw
task wr(input logic [7:0] a, input logic [31:0] v);
    int i;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
        @(posedge clk);
        if (req.awvalid && rsp.awready)
            req.awvalid <= 1'b0;
        if (req.wvalid && rsp.wready)
            req.wvalid <= 1'b0;
        if (rsp.bvalid)
        begin
            req.bready <= 1'b0;
            r = rsp.bresp;
            break;
        end
    end
    if (i == 40)
    begin
        miscompares++;
        results();
    end
endtask : wr
task rd(input logic [7:0] a);
    int i;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
        @(posedge clk);
        if (req.arvalid && rsp.arready)
            req.arvalid <= 1'b0;
        if (rsp.rvalid)
        begin
            req.rready <= 1'b0;
            d = rsp.rdata;
            r = rsp.rresp;
            break;
        end
    end
    if (i == 40)
    begin
        miscompares++;
        results();
    end
endtask : rd
task setm(input logic [7:0] c, input logic [1:0] hi);
    wr(8'h00, {24'h0, c});
    wr(8'h10, {27'h0, hi, 3'h0});
endtask : setm
// one-cycle event on timer 0; the level inputs drop with it
task ev(input logic [2:0] m, input logic [2:0] ct, input logic [2:0] cb, input logic top, input logic dn);
    @(posedge clk);
    evt[0] <= '{match: m, cmp_top: ct, cmp_bottom: cb, at_top: top, at_bottom: 1'b0, counting_down: dn};
    @(posedge clk);
    evt[0] <= '0;
    #1;
endtask : ev
initial
begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int t = 0; t < 4; t++)
    begin
        rd(8'(4 * t));
        chk("ctrl reset", 32'h0, d);
        wr(8'(4 * t), {24'hFFFFFF, 8'h3C + 8'(t)});
    end
    for (int t = 0; t < 4; t++)
    begin
        rd(8'(4 * t));
        chk("ctrl", 32'(8'h3C + 8'(t)), d);
    end
    chk("override", 32'(12'hDB6), 32'(ovr));
    wr(8'h24, 32'h1);
    chk("bresp", 32'(`RESP_SLVERR), 32'(r));
    rd(8'h24);
    chk("rresp", 32'(`RESP_SLVERR), 32'(r));
    $display("test registers done");
    setm(8'h6C, 2'h0);
    chk("override", 32'(3'b111), 32'(ovr[0]));
    ev(3'h7, 3'h0, 3'h0, 1'b0, 1'b0);
    cw(3'b101);
    ev(3'h7, 3'h0, 3'h0, 1'b0, 1'b0);
    cw(3'b100);
    chk("other timers", 32'h0, 32'(wave[3:1]));
    $display("test non-pwm done");
    setm(8'h6E, 2'h3);
    rd(8'h10);
    chk("mode high", 32'h18, d);
    ev(3'h0, 3'h0, 3'h0, 1'b1, 1'b0);
    cw(3'b010);
    ev(3'h7, 3'b110, 3'h0, 1'b0, 1'b0);
    cw(3'b011);
    setm(8'h6D, 2'h1);
    ev(3'h1, 3'h0, 3'h0, 1'b0, 1'b0);
    cw(3'b011);
    $display("test fast done");
    setm(8'h6C, 2'h2);
    ev(3'h7, 3'h0, 3'h0, 1'b0, 1'b0);
    cw(3'b100);
    ev(3'h7, 3'h0, 3'h0, 1'b0, 1'b1);
    cw(3'b011);
    ev(3'h0, 3'h0, 3'b110, 1'b0, 1'b0);
    cw(3'b101);
    ev(3'h0, 3'b110, 3'h0, 1'b0, 1'b0);
    cw(3'b011);
    setm(8'h6D, 2'h0);
    ev(3'h1, 3'h0, 3'h0, 1'b0, 1'b0);
    cw(3'b011);
    $display("test dual done");
    chk("pins released", 32'h7, 32'(pin[2:0]));
    setm(8'h2D, 2'h0);
    @(posedge clk);
    dir <= 12'h007;
    #1;
    chk("pins driven", 32'(3'b010), 32'(pin[2:0]));
    // channel A is detached now, so a match must leave it alone
    ev(3'h7, 3'h0, 3'h0, 1'b0, 1'b0);
    cw(3'b101);
    rd(8'h20);
    chk("status", 32'h0DB60005, d);
    $display("test pins done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("outputs reset", 32'h0, 32'({ovr, wave}));
    rd(8'h00);
    chk("ctrl after reset", 32'h0, d);
    $display("test reset done");
    results();
end
endmodule : timer16_compare_output_control_bench

// ===== verification/wave_ctrl_properties.sv
`timescale 1ns/1ps
module wave_ctrl_checker #(
    parameter int NUM_TIMERS = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wave_ctrl_pkg::axil_req_t axil_req,
    input wave_ctrl_pkg::axil_rsp_t axil_rsp,
    input wave_ctrl_pkg::timer_event_t [NUM_TIMERS-1:0] tmr_evt,
    input wire logic [NUM_TIMERS-1:0][2:0] wave_out,
    input wire logic [NUM_TIMERS-1:0][2:0] wave_override
);
default clocking cb @(posedge clk);
endclocking
default disable iff (rst);
a_aw_drop: assert property (axil_req.awvalid && axil_rsp.awready |=> !axil_rsp.awready)
    else $error("awready high after take");
a_b_answer: assert property (axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
    |-> ##2 axil_rsp.bvalid) else $error("no write response");
a_b_stands: assert property (axil_rsp.bvalid && !axil_req.bready
    |=> axil_rsp.bvalid && $stable(axil_rsp.bresp)) else $error("write response dropped");
a_r_answer: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid
    && !axil_rsp.arready && axil_rsp.rresp == ($past(axil_req.araddr) > 8'h23 ? 2'h2 : 2'h0))
    else $error("bad read answer");
a_r_stands: assert property (axil_rsp.rvalid && !axil_req.rready
    |=> axil_rsp.rvalid && $stable(axil_rsp.rdata)) else $error("read data moved");
a_unmapped_zero: assert property (axil_req.arvalid && axil_rsp.arready && axil_req.araddr > 8'h23
    |=> axil_rsp.rdata == 32'h0) else $error("unmapped read not zero");
a_idle_hold: assert property (tmr_evt[0].match == 3'h0 && !tmr_evt[0].at_top && tmr_evt[0].cmp_top == 3'h0
    && tmr_evt[0].cmp_bottom == 3'h0 |=> $stable(wave_out[0])) else $error("wave moved without event");
a_detached_hold: assert property (!wave_override[0][0] && !$past(rst) |-> $stable(wave_out[0][0]))
    else $error("detached channel moved");
endmodule : wave_ctrl_checker

bind wave_ctrl_top wave_ctrl_checker #(.NUM_TIMERS(NUM_TIMERS)) chk_u (.clk(clk), .rst(rst),
    .axil_req(axil_req), .axil_rsp(axil_rsp), .tmr_evt(tmr_evt), .wave_out(wave_out),
    .wave_override(wave_override));
